/* File: verilog/gscal_pkg.sv */
// Constants shared by the gas sensor calibration register logic
package gscal_pkg;

    // Holding register offsets
    localparam logic [15:0] ADDR_CAL_STATUS = 16'h0000;
    localparam logic [15:0] ADDR_CAL_COMMAND = 16'h0001;
    localparam logic [15:0] ADDR_CAL_TARGET = 16'h0002;
    localparam logic [15:0] ADDR_OVERRIDE = 16'h0003;
    localparam logic [15:0] ADDR_BASE_TIME = 16'h0004;
    localparam logic [15:0] ADDR_BASE_PAR0 = 16'h0005;
    localparam logic [15:0] ADDR_BASE_PAR1 = 16'h0006;
    localparam logic [15:0] ADDR_BASE_PAR2 = 16'h0007;

    // Calibration command codes
    localparam logic [15:0] CMD_FACTORY = 16'h7C02;
    localparam logic [15:0] CMD_FORCED_BASE = 16'h7C03;
    localparam logic [15:0] CMD_TARGET = 16'h7C05;
    localparam logic [15:0] CMD_BACKGROUND = 16'h7C06;
    localparam logic [15:0] CMD_ZERO = 16'h7C07;

    // Calibration status bit positions
    localparam int STAT_FACTORY_BIT = 2;
    localparam int STAT_BASE_BIT = 3;
    localparam int STAT_TARGET_BIT = 4;
    localparam int STAT_BACKGROUND_BIT = 5;
    localparam int STAT_ZERO_BIT = 6;

    // Reset values, hour saturation limit and period-off code
    localparam logic [15:0] OVERRIDE_NONE = 16'h7FFF;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [15:0] HOURS_MAX = 16'hFFFF;
    localparam logic [15:0] PERIOD_OFF = 16'hFFFF;

    // Hour timing
    localparam longint HOUR_S = 3600;
    localparam longint CLK_HZ = 100000000;
    localparam longint HOUR_CYCLES = HOUR_S * CLK_HZ;

    // Pending calibration state
    typedef enum logic [0:0]
    {
        GSCAL_IDLE = 1'b0,
        GSCAL_PEND = 1'b1
    } gscal_state_e;

endpackage : gscal_pkg

/* File: verilog/gscal_hour_timer.sv */
// Free-running hour tick generator
module gscal_hour_timer
    import gscal_pkg::*;
#(
    parameter longint CYCLES = HOUR_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    output logic hour_tick
);

    logic [39:0] count;

    // One-cycle tick at the end of each hour; 40 bits covers a full hour at 100 MHz
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= 40'h0000000000;
            hour_tick <= 1'b0;
        end
        else if (count == 40'(CYCLES - 1))
        begin
            count <= 40'h0000000000;
            hour_tick <= 1'b1;
        end
        else
        begin
            count <= count + 40'h0000000001;
            hour_tick <= 1'b0;
        end
    end

endmodule : gscal_hour_timer

/* File: verilog/gscal_regs.sv */
// Calibration holding registers and command decoder of the gas sensor
// How it works
// RULE1: Command 0x7C03 forces a baseline calibration if valid baseline data is held.
// RULE2: Command 0x7C03 is ignored while automatic baseline correction is disabled.
// RULE3: Command 0x7C05 calibrates the reading onto the calibration target register value.
// RULE4: Command 0x7C06 calibrates the reading onto the baseline correction target concentration.
// RULE5: Command 0x7C07 calibrates the present gas reading to zero.
// RULE6: The override register resets to 32767, meaning no override.
// RULE7: An override value below 32767 forces both filtered and unfiltered results to it.
// RULE8: The elapsed-time register counts whole hours since the last baseline calibration.
// RULE9: A power-cycling host saves, advances hourly and restores the elapsed-time register.
// RULE10: A power-cycling host saves and restores the three baseline parameter registers.
// RULE11: Each successful calibration sets its status bit until the host clears it.
// RULE12: A command is applied on the first measurement completed after it is received.
// RULE13: Command 0x7C02 restores the factory calibration.
// RULE14: An unknown command code starts nothing and leaves calibration state alone.
module gscal_regs
    import gscal_pkg::*;
#(
    parameter longint HOUR_LEN = HOUR_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_exception,
    input wire logic meas_done,
    input wire logic [15:0] meas_raw_filtered,
    input wire logic [15:0] meas_raw_unfiltered,
    input wire logic [15:0] baseline_period,
    input wire logic baseline_disable,
    input wire logic baseline_data_valid,
    input wire logic [15:0] baseline_target,
    input wire logic [15:0] baseline_lowest,
    input wire logic [15:0] factory_offset,
    output logic [15:0] cal_offset,
    output logic [15:0] conc_filtered,
    output logic [15:0] conc_unfiltered
);

    logic [15:0] calibration_status_reg;
    logic [15:0] calibration_command_reg;
    logic [15:0] calibration_target_reg;
    logic [15:0] override_reg;
    logic [15:0] baseline_time_reg;
    logic [15:0] baseline_param_0_reg;
    logic [15:0] baseline_param_1_reg;
    logic [15:0] baseline_param_2_reg;
    gscal_state_e state;
    logic [15:0] pend_cmd;
    logic hour_tick;
    logic mapped;
    logic cmd_wr;
    logic known_cmd;
    logic base_enabled;
    logic apply;
    logic cal_ok;
    logic [15:0] next_offset;
    logic [15:0] set_bits;
    logic [15:0] corr_filtered;
    logic [15:0] corr_unfiltered;

    gscal_hour_timer #(
        .CYCLES(HOUR_LEN)
    ) u_hour (
        .clk(clk),
        .rstn(rstn),
        .hour_tick(hour_tick)
    );

    // Address decode; only offsets 0 to 7 belong to this block
    assign mapped = (reg_addr <= ADDR_BASE_PAR2);
    assign cmd_wr = reg_wr && (reg_addr == ADDR_CAL_COMMAND);
    assign base_enabled = (baseline_period != RESET_ZERO) && (baseline_period != PERIOD_OFF)
                          && !baseline_disable; // RULE2
    assign apply = (state == GSCAL_PEND) && meas_done; // RULE12

    // Command codes that start a calibration
    always_comb
    begin
        case (reg_wdata)
            CMD_FACTORY: known_cmd = 1'b1;
            CMD_FORCED_BASE: known_cmd = base_enabled; // RULE2
            CMD_TARGET: known_cmd = 1'b1;
            CMD_BACKGROUND: known_cmd = 1'b1;
            CMD_ZERO: known_cmd = 1'b1;
            default: known_cmd = 1'b0; // RULE14
        endcase
    end

    // New offset and status bit for the pending command at measurement time
    always_comb
    begin
        cal_ok = 1'b1;
        next_offset = cal_offset;
        set_bits = RESET_ZERO;
        case (pend_cmd)
            CMD_FACTORY:
            begin
                next_offset = factory_offset; // RULE13
                set_bits[STAT_FACTORY_BIT] = 1'b1;
            end
            CMD_FORCED_BASE:
            begin
                // Baseline data can be lost between command and measurement, so recheck here
                cal_ok = baseline_data_valid && base_enabled; // RULE1
                next_offset = baseline_target - baseline_lowest;
                set_bits[STAT_BASE_BIT] = cal_ok;
            end
            CMD_TARGET:
            begin
                next_offset = calibration_target_reg - meas_raw_filtered; // RULE3
                set_bits[STAT_TARGET_BIT] = 1'b1;
            end
            CMD_BACKGROUND:
            begin
                next_offset = baseline_target - meas_raw_filtered; // RULE4
                set_bits[STAT_BACKGROUND_BIT] = 1'b1;
            end
            CMD_ZERO:
            begin
                next_offset = RESET_ZERO - meas_raw_filtered; // RULE5
                set_bits[STAT_ZERO_BIT] = 1'b1;
            end
            default:
            begin
                cal_ok = 1'b0;
            end
        endcase
    end

    // Pending command tracking; a later valid command replaces an unapplied one
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= GSCAL_IDLE;
            pend_cmd <= RESET_ZERO;
        end
        else if (cmd_wr && known_cmd)
        begin
            state <= GSCAL_PEND; // RULE12
            pend_cmd <= reg_wdata;
        end
        else
        begin
            case (state)
                GSCAL_PEND:
                begin
                    if (meas_done)
                    begin
                        state <= GSCAL_IDLE;
                    end
                end
                GSCAL_IDLE:
                begin
                    state <= GSCAL_IDLE;
                end
                default:
                begin
                    state <= GSCAL_IDLE;
                end
            endcase
        end
    end

    // Calibration offset, changed only by a completed calibration
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cal_offset <= RESET_ZERO;
        end
        else if (apply && cal_ok)
        begin
            cal_offset <= next_offset;
        end
    end

    // Status bits: host writes zero to clear, a calibration in the same cycle wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            calibration_status_reg <= RESET_ZERO;
        end
        else
        begin
            calibration_status_reg <= ((reg_wr && reg_addr == ADDR_CAL_STATUS)
                                       ? (calibration_status_reg & reg_wdata)
                                       : calibration_status_reg)
                                      | ((apply && cal_ok) ? set_bits : RESET_ZERO); // RULE11
        end
    end

    // Plain read/write registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            calibration_command_reg <= RESET_ZERO;
            calibration_target_reg <= RESET_ZERO;
            override_reg <= OVERRIDE_NONE; // RULE6
            baseline_param_0_reg <= RESET_ZERO;
            baseline_param_1_reg <= RESET_ZERO;
            baseline_param_2_reg <= RESET_ZERO;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CAL_COMMAND: calibration_command_reg <= reg_wdata;
                ADDR_CAL_TARGET: calibration_target_reg <= reg_wdata;
                ADDR_OVERRIDE: override_reg <= reg_wdata;
                ADDR_BASE_PAR0: baseline_param_0_reg <= reg_wdata; // RULE10
                ADDR_BASE_PAR1: baseline_param_1_reg <= reg_wdata; // RULE10
                ADDR_BASE_PAR2: baseline_param_2_reg <= reg_wdata; // RULE10
                default: calibration_command_reg <= calibration_command_reg;
            endcase
        end
    end

    // Elapsed hours: a forced baseline calibration (0x7C03) restarts it, host restore loads it, saturates at the top
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            baseline_time_reg <= RESET_ZERO;
        end
        else if (apply && cal_ok && pend_cmd == CMD_FORCED_BASE)
        begin
            baseline_time_reg <= RESET_ZERO; // RULE8
        end
        else if (reg_wr && reg_addr == ADDR_BASE_TIME)
        begin
            baseline_time_reg <= reg_wdata; // RULE9
        end
        else if (hour_tick && baseline_time_reg != HOURS_MAX)
        begin
            baseline_time_reg <= baseline_time_reg + 16'h0001; // RULE8
        end
    end

    // Results: calibrated readings unless an override is active
    assign corr_filtered = meas_raw_filtered + cal_offset;
    assign corr_unfiltered = meas_raw_unfiltered + cal_offset;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conc_filtered <= RESET_ZERO;
            conc_unfiltered <= RESET_ZERO;
        end
        else if (override_reg < OVERRIDE_NONE)
        begin
            conc_filtered <= override_reg; // RULE7
            conc_unfiltered <= override_reg; // RULE7
        end
        else
        begin
            conc_filtered <= corr_filtered;
            conc_unfiltered <= corr_unfiltered;
        end
    end

    // Read port: one cycle latency, exception for an unmapped offset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= RESET_ZERO;
            reg_rd_valid <= 1'b0;
            reg_exception <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd && mapped;
            reg_exception <= (reg_rd || reg_wr) && !mapped;
            case (reg_addr)
                ADDR_CAL_STATUS: reg_rdata <= calibration_status_reg;
                ADDR_CAL_COMMAND: reg_rdata <= calibration_command_reg;
                ADDR_CAL_TARGET: reg_rdata <= calibration_target_reg;
                ADDR_OVERRIDE: reg_rdata <= override_reg;
                ADDR_BASE_TIME: reg_rdata <= baseline_time_reg;
                ADDR_BASE_PAR0: reg_rdata <= baseline_param_0_reg;
                ADDR_BASE_PAR1: reg_rdata <= baseline_param_1_reg;
                ADDR_BASE_PAR2: reg_rdata <= baseline_param_2_reg;
                default: reg_rdata <= RESET_ZERO;
            endcase
        end
    end

endmodule : gscal_regs

/* File: testbench/gscal_host.sv */
// Register host model driving the holding-register request port
module gscal_host
(
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_exception
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // One write; released lines flip so a stale value never looks valid
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    // Answer stands only in the cycle after the request edge, so take it there
    task rd(input logic [15:0] a, output logic [15:0] d, output logic v, output logic e);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
        v = reg_rd_valid;
        e = reg_exception;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : gscal_host

/* File: testbench/gscal_regs_monitor.sv */
// Property checker for the calibration register block
module gscal_regs_monitor
    import gscal_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic meas_done,
    input wire logic [15:0] meas_raw_filtered,
    input wire logic [15:0] baseline_period,
    input wire logic baseline_disable,
    input wire logic baseline_data_valid,
    input wire logic [15:0] baseline_target,
    input wire logic [15:0] baseline_lowest,
    input wire logic [15:0] factory_offset,
    input wire logic [15:0] cal_offset,
    input wire logic [15:0] conc_filtered,
    input wire logic [15:0] conc_unfiltered
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic pend;
    logic [15:0] pcmd;
    logic [15:0] tgt;
    logic cw;
    logic on;
    logic ap;
    // Known codes only; anything else must not arm a calibration
    assign cw = reg_wr && reg_addr == ADDR_CAL_COMMAND && (reg_wdata inside
        {CMD_FACTORY, CMD_FORCED_BASE, CMD_TARGET, CMD_BACKGROUND, CMD_ZERO});
    assign on = !baseline_disable && baseline_period != 16'h0000 && baseline_period != PERIOD_OFF;
    assign ap = meas_done && pend;
    // Pending command; a write in the measurement cycle stays pending
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend <= 1'b0;
            pcmd <= 16'h0000;
        end
        else if (cw)
        begin
            pend <= 1'b1;
            pcmd <= reg_wdata;
        end
        else if (meas_done)
            pend <= 1'b0;
    end
    // Shadow of the target register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tgt <= 16'h0000;
        else if (reg_wr && reg_addr == ADDR_CAL_TARGET)
            tgt <= reg_wdata;
    end
    property p_fac;
        ap && pcmd == CMD_FACTORY |=> cal_offset == $past(factory_offset);
    endproperty
    a_fac: assert property (p_fac) else $error("factory offset wrong");
    property p_frc;
        ap && pcmd == CMD_FORCED_BASE && on && baseline_data_valid
            |=> cal_offset == $past(baseline_target - baseline_lowest);
    endproperty
    a_frc: assert property (p_frc) else $error("forced offset wrong");
    property p_off;
        ap && pcmd == CMD_FORCED_BASE && !on |=> $stable(cal_offset);
    endproperty
    a_off: assert property (p_off) else $error("forced ran while off");
    property p_inv;
        ap && pcmd == CMD_FORCED_BASE && !baseline_data_valid |=> $stable(cal_offset);
    endproperty
    a_inv: assert property (p_inv) else $error("forced ran without baseline data");
    property p_tgt;
        ap && pcmd == CMD_TARGET |=> cal_offset == $past(tgt - meas_raw_filtered);
    endproperty
    a_tgt: assert property (p_tgt) else $error("target offset wrong");
    property p_bkg;
        ap && pcmd == CMD_BACKGROUND |=> cal_offset == $past(baseline_target - meas_raw_filtered);
    endproperty
    a_bkg: assert property (p_bkg) else $error("background offset wrong");
    property p_zro;
        ap && pcmd == CMD_ZERO |=> cal_offset == $past(16'h0000 - meas_raw_filtered);
    endproperty
    a_zro: assert property (p_zro) else $error("zero offset wrong");
    property p_idle;
        !meas_done |=> $stable(cal_offset);
    endproperty
    a_idle: assert property (p_idle) else $error("offset moved off a measurement");
    property p_unk;
        meas_done && !pend |=> $stable(cal_offset);
    endproperty
    a_unk: assert property (p_unk) else $error("offset moved with nothing armed");
    property p_ovr;
        (reg_wr && reg_addr == ADDR_OVERRIDE && reg_wdata < OVERRIDE_NONE)
            ##1 !(reg_wr && reg_addr == ADDR_OVERRIDE)
            |=> conc_filtered == $past(reg_wdata, 2) && conc_unfiltered == $past(reg_wdata, 2);
    endproperty
    a_ovr: assert property (p_ovr) else $error("override not applied");
endmodule : gscal_regs_monitor

bind gscal_regs gscal_regs_monitor mon (.clk, .rstn, .reg_wr, .reg_addr, .reg_wdata,
    .meas_done, .meas_raw_filtered, .baseline_period, .baseline_disable, .baseline_data_valid,
    .baseline_target, .baseline_lowest, .factory_offset, .cal_offset, .conc_filtered,
    .conc_unfiltered);

/* File: testbench/gscal_regs_tb.sv */
// Self-checking bench for the calibration register block
module gscal_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gscal_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic md = 1'b0;
    logic dis = 1'b0;
    logic bv = 1'b1;
    logic reg_wr, reg_rd, v, e, rdv, exc;
    logic [15:0] rf = 16'h0000, ru = 16'h0000, per = 16'h00B4, bt = 16'h0190;
    logic [15:0] bl = 16'h0120, fo = 16'h0011, lat = 16'h0000, eo = 16'h0000;
    logic [15:0] reg_addr, reg_wdata, rdata, off, cf, cu, d, x;
    logic [15:0] regs [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h7FFF,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] cmds [6] = '{CMD_FACTORY, CMD_FORCED_BASE, CMD_TARGET, CMD_BACKGROUND,
        CMD_ZERO, 16'h7C04};
    int mismatches = 0;
    int comparisons = 0;
    int seed = 32'h7CC4;
    gscal_regs #(.HOUR_LEN(20)) dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rd_valid(rdv),
        .reg_exception(exc), .meas_done(md), .meas_raw_filtered(rf), .meas_raw_unfiltered(ru),
        .baseline_period(per), .baseline_disable(dis), .baseline_data_valid(bv),
        .baseline_target(bt), .baseline_lowest(bl), .factory_offset(fo), .cal_offset(off),
        .conc_filtered(cf), .conc_unfiltered(cu));
    gscal_host h (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rd_valid(rdv), .reg_exception(exc));
    // Clock and hang guard
    initial
        forever #5 clk = ~clk;
    initial
    begin
        #100us;
        mismatches++;
        wrap_up;
    end
    task chk(input string n, input logic [15:0] s, input logic [15:0] w);
        comparisons++;
        if (s !== w)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, w, s);
        end
    endtask : chk
    task rdchk(input logic [15:0] a, input logic [15:0] w);
        h.rd(a, d, v, e);
        chk("rdata", d, w);
        chk("rd_valid", {15'h0000, v}, 16'h0001);
    endtask : rdchk
    // Measurement pulse; filtered reading is taken with it
    task meas;
        @(negedge clk);
        md = 1'b1;
        rf = 16'($random(seed));
        @(negedge clk);
        md = 1'b0;
        lat = rf;
    endtask : meas
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        for (int a = 0; a < 8; a++)
            rdchk(16'(a), regs[a]);
        h.rd(16'h0008, d, v, e);
        chk("exception", {15'h0000, e}, 16'h0001);
        $display("test reset done");
        for (int a = 2; a < 8; a++)
            if (a != 4)
            begin
                regs[a] = (a == 3) ? 16'h7FFF : 16'($random(seed));
                h.wr(16'(a), regs[a]);
                rdchk(16'(a), regs[a]);
            end
        $display("test store done");
        for (int i = 0; i < 6; i++)
        begin
            h.wr(ADDR_CAL_STATUS, 16'h0000);
            h.wr(ADDR_CAL_COMMAND, cmds[i]);
            meas;
            case (i)
                0: eo = fo;
                1: eo = bt - bl;
                2: eo = regs[2] - lat;
                3: eo = bt - lat;
                4: eo = 16'h0000 - lat;
                default: eo = eo;
            endcase
            chk("cal_offset", off, eo);
            rdchk(ADDR_CAL_STATUS, (i < 5) ? (16'h0004 << i) : 16'h0000);
            rdchk(ADDR_CAL_COMMAND, cmds[i]);
        end
        $display("test commands done");
        // Disable bit, period off, no baseline data, period zero
        for (int j = 0; j < 4; j++)
        begin
            dis = (j == 0);
            per = (j == 1) ? PERIOD_OFF : ((j == 3) ? 16'h0000 : 16'h00B4);
            bv = (j != 2);
            h.wr(ADDR_CAL_COMMAND, CMD_FORCED_BASE);
            meas;
            chk("cal_offset", off, eo);
            rdchk(ADDR_CAL_STATUS, 16'h0000);
        end
        dis = 1'b0;
        bv = 1'b1;
        per = 16'h00B4;
        $display("test disabled done");
        ru = 16'($random(seed));
        x = 16'($random(seed)) & 16'h7FFE;
        h.wr(ADDR_OVERRIDE, x);
        @(negedge clk);
        chk("conc_filtered", cf, x);
        chk("conc_unfiltered", cu, x);
        h.wr(ADDR_OVERRIDE, 16'h7FFF);
        @(negedge clk);
        chk("conc_filtered", cf, lat + eo);
        chk("conc_unfiltered", cu, ru + eo);
        $display("test override done");
        h.rd(ADDR_BASE_TIME, x, v, e);
        // Twenty edges between the two samples hold exactly one hour tick
        repeat (19) @(posedge clk);
        rdchk(ADDR_BASE_TIME, x + 16'h0001);
        h.wr(ADDR_BASE_TIME, HOURS_MAX);
        repeat (25) @(posedge clk);
        rdchk(ADDR_BASE_TIME, HOURS_MAX);
        $display("test hours done");
        wrap_up;
    end
endmodule : gscal_regs_tb
